// ### core/sram_host_ctrl.sv
// Host controller that drives a 4096 x 4 asynchronous static memory through its pins.
//
// Contract
// - A read exists while strobe is high and select low, timed from the later of select fall and address valid.
// - A select-started read gives data at select access time only if the address is stable within 5 ns.
// - The host sets the address up before a write begins.
// - The host keeps the address steady through the whole write and changes it only after the ending edge.
// - In a strobe-ended write data is held across the strobe rise and read-back equals the word written.
`timescale 1ns/1ps
module sram_host_ctrl
   import sram_host_pkg::*;
#(
   parameter int POWER_UP_CYC = POWER_UP_CYC_DEF
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [DATA_W-1:0] reqData,
   output logic reqReady,
   output logic rspValid,
   output logic [DATA_W-1:0] rspData,
   output logic memSelect_b,
   output logic memWrite_b,
   output logic [ADDR_W-1:0] memAddr,
   output logic [DATA_W-1:0] memDataOut,
   output logic memDataOe,
   input wire logic [DATA_W-1:0] memDataIn
);
   // ------------------------------------------------------------------
   // States
   // ------------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_POWER = 6'h01,
      ST_IDLE = 6'h02,
      ST_RSEL = 6'h04,
      ST_WSEL = 6'h08,
      ST_WSTB = 6'h10,
      ST_WEND = 6'h20
   } state_t;

   state_t state_q, state_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic sel_b_q, sel_b_d, wr_b_q, wr_b_d, oe_q, oe_d, rsp_q, rsp_d;
   logic load;
   logic [CNT_W-1:0] loadValue;
   logic done;
   logic [DATA_W-1:0] dinMeta_q, dinSync_q;
   logic [CNT_W+6:0] pwrCnt_q, pwrCnt_d;
   logic pwrDone;

   // ------------------------------------------------------------------
   // Data pin synchroniser
   // ------------------------------------------------------------------
   // The memory answers asynchronously, so the read word passes two flops.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dinMeta_q <= DATA_RESET;
         dinSync_q <= DATA_RESET;
      end else begin
         dinMeta_q <= memDataIn;
         dinSync_q <= dinMeta_q;
      end
   end

   sram_host_timer timer (
      .clk(clk),
      .rst_b(rst_b),
      .load(load),
      .loadValue(loadValue),
      .done(done)
   );

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      sel_b_d = sel_b_q;
      wr_b_d = wr_b_q;
      oe_d = oe_q;
      rsp_d = 1'b0;
      load = 1'b0;
      loadValue = CNT_RESET;
      unique case (state_q)
         ST_POWER: begin
            if (pwrDone) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (reqValid) begin
               addr_d = reqAddr;
               wdata_d = reqData;
               load = 1'b1;
               if (reqWrite) begin
                  // Address settles a cycle before select falls.
                  state_d = ST_WSEL;
                  loadValue = 16'h0000;
               end else begin
                  // Select and address change together, well inside the 5 ns skew.
                  sel_b_d = 1'b0;
                  wr_b_d = 1'b1;
                  state_d = ST_RSEL;
                  loadValue = CNT_W'(ACCESS_CYC + 2);
               end
            end
         end
         ST_RSEL: begin
            if (done) begin
               rdata_d = dinSync_q;
               rsp_d = 1'b1;
               sel_b_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
         ST_WSEL: begin
            sel_b_d = 1'b0;
            wr_b_d = 1'b0;
            oe_d = 1'b1;
            load = 1'b1;
            loadValue = CNT_W'(WRITE_PULSE_CYC);
            state_d = ST_WSTB;
         end
         ST_WSTB: begin
            if (done) begin
               // Strobe ends the write; data and address stay one more cycle.
               wr_b_d = 1'b1;
               state_d = ST_WEND;
            end
         end
         ST_WEND: begin
            oe_d = 1'b0;
            sel_b_d = 1'b1;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // The first cycle after reset arms the power-up wait.
   logic armed_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_POWER;
         addr_q <= ADDR_RESET;
         wdata_q <= DATA_RESET;
         rdata_q <= DATA_RESET;
         sel_b_q <= 1'b1;
         wr_b_q <= 1'b1;
         oe_q <= 1'b0;
         rsp_q <= 1'b0;
      end else if (!armed_q) begin
         state_q <= ST_POWER;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         sel_b_q <= sel_b_d;
         wr_b_q <= wr_b_d;
         oe_q <= oe_d;
         rsp_q <= rsp_d;
      end
   end

   // Power-up count is loaded through a second timer port-free path.
   assign pwrDone = (pwrCnt_q == '0);
   always_comb begin
      pwrCnt_d = pwrCnt_q;
      if (state_q == ST_POWER && pwrCnt_q != '0) begin
         pwrCnt_d = pwrCnt_q - 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwrCnt_q <= '1;
      end else if (!armed_q) begin
         pwrCnt_q <= (CNT_W+7)'(POWER_UP_CYC);
      end else begin
         pwrCnt_q <= pwrCnt_d;
      end
   end

   assign reqReady = (state_q == ST_IDLE);
   assign rspValid = rsp_q;
   assign rspData = rdata_q;
   assign memSelect_b = sel_b_q | (state_q == ST_POWER);
   assign memWrite_b = wr_b_q;
   assign memAddr = addr_q;
   assign memDataOut = wdata_q;
   assign memDataOe = oe_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   power_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == ST_POWER) |-> memSelect_b && memWrite_b && !memDataOe)
      else $error("Select low during power-up wait.");
   power_time_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == ST_POWER && armed_q && pwrCnt_q != '0) |=> state_q == ST_POWER)
      else $error("Power-up wait left early.");
   read_strobe_a: assert property (@(posedge clk) disable iff (!rst_b) (!memSelect_b && !oe_q) |-> memWrite_b)
      else $error("Strobe low while reading.");
   read_release_a: assert property (@(posedge clk) disable iff (!rst_b) (state_q == ST_RSEL) |-> !memDataOe)
      else $error("Host drives data during read.");
   write_addr_a: assert property (@(posedge clk) disable iff (!rst_b) !memWrite_b |=> $stable(memAddr))
      else $error("Address moved during write.");
   write_data_a: assert property (@(posedge clk) disable iff (!rst_b) $rose(memWrite_b) && memDataOe |-> memDataOe && !memSelect_b)
      else $error("Data or select dropped at strobe rise.");
   write_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) $fell(memWrite_b) |-> !memWrite_b [*2])
      else $error("Write pulse too short.");
   write_sel_a: assert property (@(posedge clk) disable iff (!rst_b) !memWrite_b |-> !memSelect_b && memDataOe)
      else $error("Write without select or data.");
   read_resp_a: assert property (@(posedge clk) disable iff (!rst_b) $fell(memSelect_b) && memWrite_b |-> ##[2:5] rspValid)
      else $error("Read answer late.");
endmodule : sram_host_ctrl

// ### core/sram_host_pkg.sv
// Constants shared by the asynchronous static memory host controller.
package sram_host_pkg;
   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 4;
   // ------------------------------------------------------------------
   // Timing, in nanoseconds and in 100 ns clock cycles
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int POWER_UP_NS = 2000000;
   localparam int POWER_UP_CYC_DEF = POWER_UP_NS / CLK_PERIOD_NS;
   localparam int ACCESS_NS = 70;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_PULSE_NS = 65;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 4'h0;
endpackage : sram_host_pkg

// ### core/sram_host_timer.sv
// Down counter that paces the read access and write strobe phases of the host controller.
`timescale 1ns/1ps
module sram_host_timer
   import sram_host_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [CNT_W-1:0] loadValue,
   output logic done
);
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;

   always_comb begin
      count_d = count_q;
      if (load) begin
         count_d = loadValue;
      end else if (count_q != CNT_RESET) begin
         count_d = count_q - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= CNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   assign done = (count_q == CNT_RESET) && !load;
endmodule : sram_host_timer

// ### verif/sram_mem_model.sv
// Behavioural model of the 4096 x 4 asynchronous static memory on the far side.
`timescale 1ns/1ps
module sram_mem_model
   import sram_host_pkg::*;
#(
   parameter int POWER_NS = 1000,
   parameter int ACC_NS = ACCESS_NS
)
(
   input wire logic select_b,
   input wire logic write_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] hostData,
   input wire logic hostOe,
   output logic [DATA_W-1:0] level,
   output logic contention
);
   // ------------------------------------------------------------------
   // Storage and modes
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] mem [0:4095];
   logic [DATA_W-1:0] rdData = DATA_RESET;
   logic [DATA_W-1:0] lastLevel = DATA_RESET;
   logic powered = 1'b0;
   logic writing = 1'b0;
   logic reading;
   initial begin
      // Cells start from a pattern unlike every word the scenarios write, so a lost write shows.
      for (int i = 0; i < 4096; i++) mem[i] = 4'(i) ^ 4'h9;
      #(POWER_NS) powered = 1'b1;
   end
   assign reading = powered && !select_b && write_b;
   // A host still driving the word just written is no conflict, as the memory shows that same word.
   assign contention = reading && hostOe && (rdData !== hostData);
   // One process stores first and then starts the read, so a read never races a write that ends together.
   always @(select_b or write_b or addr) begin
      if (writing && (select_b || write_b)) begin
         mem[addr] = level;
         rdData = level;
      end
      writing = powered && !select_b && !write_b;
      // Old data holds until one access time after the later of select and address.
      if (powered && !select_b && write_b) rdData <= #(ACC_NS) mem[addr];
   end
   // The lines have no pull, so released lines show the inverse of the last value.
   always @* begin
      if (hostOe) level = hostData;
      else if (reading) level = rdData;
      else level = ~lastLevel;
   end
   always @(level) if (hostOe || reading) lastLevel <= level;
endmodule : sram_mem_model

// ### verif/tb_top.sv
// Self-checking testbench for the static memory host controller.
`timescale 1ns/1ps
module tb_top;
   import sram_host_pkg::*;
   // ------------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------------
   localparam int PU = 10;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   logic [ADDR_W-1:0] reqAddr = ADDR_RESET;
   logic [ADDR_W-1:0] prevAddr = ADDR_RESET;
   logic [ADDR_W-1:0] memAddr;
   logic [DATA_W-1:0] reqData = DATA_RESET;
   logic [DATA_W-1:0] rspData, memDataOut, memDataIn, q;
   logic reqReady, rspValid, memSelect_b, memWrite_b, memDataOe, contention;
   int fail_count = 0;
   int num_checks = 0;
   always #50 clk = ~clk;
   sram_host_ctrl #(.POWER_UP_CYC(PU)) uut (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .memSelect_b(memSelect_b), .memWrite_b(memWrite_b), .memAddr(memAddr), .memDataOut(memDataOut),
      .memDataOe(memDataOe), .memDataIn(memDataIn));
   sram_mem_model #(.POWER_NS(PU * CLK_PERIOD_NS)) memModel (.select_b(memSelect_b), .write_b(memWrite_b),
      .addr(memAddr), .hostData(memDataOut), .hostOe(memDataOe), .level(memDataIn), .contention(contention));
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic timeout();
      fail_count++;
      $display("Error at %0t ns: wait ran out", $time);
      results();
   endtask : timeout
   // Called at a falling edge; a read leaves its word in q.
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      reqValid = 1'b1;
      reqWrite = wr;
      reqAddr = a;
      reqData = d;
      n = 0;
      while (reqReady !== 1'b1) begin
         @(negedge clk);
         if (++n > 50) timeout();
      end
      @(negedge clk);
      reqValid = 1'b0;
      if (!wr) begin
         n = 1;
         while (rspValid !== 1'b1) begin
            @(negedge clk);
            if (++n > 8) timeout();
         end
         q = rspData;
         check(n >= 4 && n <= 5, 1'b1);
      end
      @(negedge clk);
   endtask : access
   // Strobe only while selected, with address steady from the cycle before and data driven.
   always @(negedge clk) begin
      if (contention === 1'b1) check(1'b1, 1'b0);
      if (memWrite_b === 1'b0) begin
         check(memAddr, prevAddr);
         check(memSelect_b, 1'b0);
         check(memDataOe, 1'b1);
      end
      prevAddr = memAddr;
   end
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_powerup();
      int n;
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      check(memSelect_b, 1'b1);
      check(memDataOe, 1'b0);
      rst_b = 1'b1;
      n = 0;
      while (reqReady !== 1'b1) begin
         check(memSelect_b, 1'b1);
         @(negedge clk);
         if (++n > 4 * PU) timeout();
      end
      check(n >= PU, 1'b1);
      $display("Test powerup done");
   endtask : test_powerup
   task automatic test_corners();
      logic [ADDR_W-1:0] addrs [4] = '{12'h000, 12'hFFF, 12'h800, 12'h001};
      logic [DATA_W-1:0] datas [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
      for (int i = 0; i < 4; i++) begin
         access(1'b1, addrs[i], datas[i]);
         access(1'b0, addrs[i], DATA_RESET);
         check(q, datas[i]);
      end
      $display("Test corners done");
   endtask : test_corners
   task automatic test_b2b();
      for (int i = 0; i < 4; i++) access(1'b1, 12'h7FE + i[11:0], 4'h3 + i[3:0]);
      for (int i = 0; i < 4; i++) begin
         access(1'b0, 12'h7FE + i[11:0], DATA_RESET);
         check(q, 4'h3 + i[3:0]);
      end
      $display("Test back to back done");
   endtask : test_b2b
   // After a long deselect the earlier words must still read back.
   task automatic test_retain();
      access(1'b0, 12'h000, DATA_RESET);
      check(q, 4'h5);
      access(1'b0, 12'hFFF, DATA_RESET);
      check(q, 4'hA);
      $display("Test retain done");
   endtask : test_retain
   initial begin
      test_powerup();
      test_corners();
      test_b2b();
      test_powerup();
      test_retain();
      results();
   end
endmodule : tb_top
